// File: common/emc_pkg.sv
// constants and types for the measurement-control block
package emc_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SEC_NS = 1_000_000_000;
  localparam int unsigned CYC_PER_SEC = SEC_NS / CLK_PERIOD_NS;
  localparam logic [19:0] SEC_PER_MIN = 20'd60;
  localparam logic [19:0] SEC_PER_HOUR = 20'd3600;
  localparam logic [19:0] SEC_PER_DAY = 20'd86400;
  localparam logic [19:0] MAX_SECONDS = 20'd864000;
  localparam logic [3:0] MAX_DAY = 4'ha;
  localparam logic [4:0] MAX_HOUR = 5'h17;
  localparam logic [5:0] MAX_MINSEC = 6'h3b;
  localparam logic [6:0] PRBS_SYNC_LAST = 7'h7f;
  localparam int unsigned DIV16_BIT = 3;
  localparam int unsigned DIV64_BIT = 5;
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_DAY = 8'h08;
  localparam logic [7:0] OFS_HMS = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_ELAPSED = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
  // field positions
  localparam int unsigned CMD_START_BIT = 0;
  localparam int unsigned CMD_STOP_BIT = 1;
  localparam int unsigned HMS_SEC_LSB = 0;
  localparam int unsigned HMS_MIN_LSB = 8;
  localparam int unsigned HMS_HOUR_LSB = 16;
  localparam int unsigned IRQ_W = 4;
  // reset values
  localparam logic [8:0] CTRL_RST = 9'h008;
  localparam logic [3:0] DAY_RST = 4'h0;
  localparam logic [5:0] SEC_RST = 6'h01;
  localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;

  typedef enum logic [1:0] {MODE_SINGLE, MODE_MANUAL, MODE_REPEAT} emc_mode_e;
  typedef enum logic [2:0] {
    TRIG_TX_DIV16, TRIG_TX_DIV64, TRIG_TX_PATT, TRIG_TX_ERR,
    TRIG_RX_DIV16, TRIG_RX_DIV64, TRIG_RX_PATT, TRIG_RX_ERR
  } emc_trig_e;
  typedef enum logic {ST_IDLE, ST_RUN} emc_state_e;

  // control register layout, lsb last
  typedef struct packed {
    logic [2:0] trig_sel;
    logic [1:0] alert_vol;
    logic auto_sync;
    logic input_sel;
    logic [1:0] mode;
  } emc_ctrl_s;

  // event strobes from pattern generator and error detector
  typedef struct packed {
    logic tx_err_ins;
    logic rx_err_det;
    logic tx_pat_wrap;
    logic rx_pat_wrap;
  } emc_ev_s;

  // irq bits: done, interval end, rx error, tx error
  typedef struct packed {
    logic tx_err;
    logic rx_err;
    logic interval;
    logic done;
  } emc_irq_s;
endpackage : emc_pkg

// File: src/emc_measure_ctrl.sv
// measurement interval gating, trigger selection and input path control
//
// Behaviour
// R1: single mode runs from start for the set period, then stops itself.
// R2: manual mode runs start to stop, ending itself at ten days.
// R3: repeat mode runs back-to-back periods after start until stop.
// R4: day part of the period is 0 to 10 in whole days.
// R5: time part spans 00:00:01 to 23:59:59 with one-second steps.
// R6: whole period never exceeds ten days.
// R7: period setting applies to single and repeat only, not manual.
// R8: each detected error requests an alert at off, soft, medium or loud.
// R9: transmit divider source gives transmit clock over 16 or 64.
// R10: receive divider source gives input or recovered clock over 16 or 64.
// R11: transmit pattern source pulses with pattern; every 128 cycles for prbs.
// R12: receive pattern source pulses with input pattern; every 128 for prbs.
// R13: transmit error source pulses per inserted error.
// R14: receive error source pulses per detected error.
// R15: one shared trigger selection for generator and detector.
// R16: input 1 uses clock recovery; input 2 bypasses it, needing external clock.
// R17: automatic resynchronisation can be switched on or off.
// R18: event triggers are single clock-cycle pulses.
// R19: start while running and stop while idle are ignored.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
module emc_measure_ctrl
  import emc_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = CYC_PER_SEC
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  // link side
  input wire logic tx_clk,
  input wire logic rec_clk,
  input wire logic ext_clk,
  input wire logic data_in1,
  input wire logic data_in2,
  input wire logic pat_is_prbs,
  input wire emc_ev_s ev,
  // outputs
  output logic trig_out,
  output logic rx_data,
  output logic rx_data_valid,
  output logic cdr_enable,
  output logic resync_en,
  output logic alert_req,
  output logic [1:0] alert_level,
  output logic measuring,
  output logic meas_done,
  output logic interval_end
);
  localparam int unsigned TW = $clog2(SEC_CYCLES + 1);

  emc_ctrl_s ctrl_q;
  logic [3:0] day_q;
  logic [4:0] hour_q;
  logic [5:0] min_q;
  logic [5:0] sec_q;
  emc_irq_s stat_q, stat_d, ev_now;
  logic [IRQ_W-1:0] mask_q;
  logic [31:0] rdata_q;
  emc_state_e state_q;
  logic [19:0] elapsed_q, limit_q, period_c, hms_c;
  logic [TW-1:0] tick_q;
  logic sec_tick;
  logic done_q, intv_q;
  logic [4:0] a_wdata_day;
  logic wr_ctrl, wr_cmd, wr_day, wr_hms, wr_stat, wr_mask;
  logic start_cmd, stop_cmd;
  logic [1:0] ch_clk, ch_wrap, ch_rise, ch_patt;
  logic [1:0] ch_clk_q, ch_wrap_q;
  logic [5:0] ch_div_q [2];
  logic [6:0] ch_pat_q [2];
  logic tx_err_q, rx_err_q, tx_err_p, rx_err_p;
  logic trig_q, trig_d;
  logic rxd_q, rxv_q, alert_q;

  // register decode
  assign wr_ctrl = reg_wr && reg_addr == OFS_CTRL;
  assign wr_cmd = reg_wr && reg_addr == OFS_CMD;
  assign wr_day = reg_wr && reg_addr == OFS_DAY;
  assign wr_hms = reg_wr && reg_addr == OFS_HMS;
  assign wr_stat = reg_wr && reg_addr == OFS_IRQ_STAT;
  assign wr_mask = reg_wr && reg_addr == OFS_IRQ_MASK;
  assign start_cmd = wr_cmd && reg_wdata[CMD_START_BIT];
  assign stop_cmd = wr_cmd && reg_wdata[CMD_STOP_BIT];
  assign a_wdata_day = reg_wdata[4:0];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RST;
    end else if (clk_en && wr_ctrl) begin
      ctrl_q <= reg_wdata[8:0]; // [R15]
    end
  end

  // saturate period fields on write so each stored field stays within its range
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      day_q <= DAY_RST;
      hour_q <= 5'h00;
      min_q <= 6'h00;
      sec_q <= SEC_RST;
    end else if (clk_en) begin
      if (wr_day) begin
        day_q <= (a_wdata_day > {1'b0, MAX_DAY}) ? MAX_DAY : a_wdata_day[3:0]; // [R4]
      end
      if (wr_hms) begin
        hour_q <= (reg_wdata[HMS_HOUR_LSB +: 5] > MAX_HOUR) ? MAX_HOUR : reg_wdata[HMS_HOUR_LSB +: 5]; // [R5]
        min_q <= (reg_wdata[HMS_MIN_LSB +: 6] > MAX_MINSEC) ? MAX_MINSEC : reg_wdata[HMS_MIN_LSB +: 6]; // [R5]
        sec_q <= (reg_wdata[HMS_SEC_LSB +: 6] > MAX_MINSEC) ? MAX_MINSEC : reg_wdata[HMS_SEC_LSB +: 6]; // [R5]
      end
    end
  end

  // period in seconds
  always_comb begin
    hms_c = 20'(hour_q) * SEC_PER_HOUR + 20'(min_q) * SEC_PER_MIN + 20'(sec_q);
    if (hms_c == 20'h00000) begin
      hms_c = 20'h00001; // [R5]
    end
    period_c = 20'(day_q) * SEC_PER_DAY + hms_c;
    if (period_c > MAX_SECONDS) begin
      period_c = MAX_SECONDS; // [R6]
    end
  end

  // one-second time base, restarted with each measurement
  assign sec_tick = state_q == ST_RUN && tick_q == TW'(SEC_CYCLES - 1);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tick_q <= '0;
    end else if (clk_en) begin
      if (state_q == ST_IDLE || sec_tick) begin
        tick_q <= '0;
      end else begin
        tick_q <= tick_q + TW'(1);
      end
    end
  end

  // measurement sequencer
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      elapsed_q <= 20'h00000;
      limit_q <= MAX_SECONDS;
      done_q <= 1'b0;
      intv_q <= 1'b0;
    end else if (clk_en) begin
      done_q <= 1'b0;
      intv_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start_cmd) begin // [R19]
            state_q <= ST_RUN;
            elapsed_q <= 20'h00000;
            // period latched at start; manual ignores it
            case (emc_mode_e'(ctrl_q.mode))
              MODE_SINGLE, MODE_REPEAT: limit_q <= period_c; // [R7]
              default: limit_q <= MAX_SECONDS; // [R2] [R7]
            endcase
          end
        end
        ST_RUN: begin
          if (stop_cmd) begin // [R2] [R3]
            state_q <= ST_IDLE;
            done_q <= 1'b1;
          end else if (sec_tick) begin
            if (elapsed_q + 20'h00001 >= limit_q) begin
              if (emc_mode_e'(ctrl_q.mode) == MODE_REPEAT) begin
                elapsed_q <= 20'h00000; // [R3]
                intv_q <= 1'b1;
              end else begin
                elapsed_q <= limit_q;
                state_q <= ST_IDLE; // [R1] [R2]
                done_q <= 1'b1;
              end
            end else begin
              elapsed_q <= elapsed_q + 20'h00001;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  assign measuring = state_q == ST_RUN;
  assign meas_done = done_q;
  assign interval_end = intv_q;

  // channel 0 transmit, channel 1 receive; receive clock follows input select
  assign ch_clk = {ctrl_q.input_sel ? ext_clk : rec_clk, tx_clk}; // [R10] [R16]
  assign ch_wrap = {ev.rx_pat_wrap, ev.tx_pat_wrap};

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      assign ch_rise[ch] = ch_clk[ch] && !ch_clk_q[ch];
      // prbs sync derived from cycle count, other patterns from wrap strobe
      assign ch_patt[ch] = pat_is_prbs ? (ch_rise[ch] && ch_pat_q[ch] == PRBS_SYNC_LAST)
                                       : (ch_wrap[ch] && !ch_wrap_q[ch]); // [R11] [R12] [R18]
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          ch_clk_q[ch] <= 1'b0;
          ch_wrap_q[ch] <= 1'b0;
          ch_div_q[ch] <= 6'h00;
          ch_pat_q[ch] <= 7'h00;
        end else if (clk_en) begin
          ch_clk_q[ch] <= ch_clk[ch];
          ch_wrap_q[ch] <= ch_wrap[ch];
          if (ch_rise[ch]) begin
            ch_div_q[ch] <= ch_div_q[ch] + 6'h01; // [R9] [R10]
            ch_pat_q[ch] <= ch_pat_q[ch] + 7'h01;
          end
        end
      end
    end
  endgenerate

  // error strobes cut to one cycle even if held longer
  assign tx_err_p = ev.tx_err_ins && !tx_err_q;
  assign rx_err_p = ev.rx_err_det && !rx_err_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_err_q <= 1'b0;
      rx_err_q <= 1'b0;
    end else if (clk_en) begin
      tx_err_q <= ev.tx_err_ins;
      rx_err_q <= ev.rx_err_det;
    end
  end

  // trigger source select
  always_comb begin
    case (emc_trig_e'(ctrl_q.trig_sel))
      TRIG_TX_DIV16: trig_d = ch_div_q[0][DIV16_BIT]; // [R9]
      TRIG_TX_DIV64: trig_d = ch_div_q[0][DIV64_BIT]; // [R9]
      TRIG_TX_PATT: trig_d = ch_patt[0]; // [R11]
      TRIG_TX_ERR: trig_d = tx_err_p; // [R13] [R18]
      TRIG_RX_DIV16: trig_d = ch_div_q[1][DIV16_BIT]; // [R10]
      TRIG_RX_DIV64: trig_d = ch_div_q[1][DIV64_BIT]; // [R10]
      TRIG_RX_PATT: trig_d = ch_patt[1]; // [R12]
      TRIG_RX_ERR: trig_d = rx_err_p; // [R14] [R18]
      default: trig_d = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      trig_q <= 1'b0;
    end else if (clk_en) begin
      trig_q <= trig_d;
    end
  end

  assign trig_out = trig_q;

  // data sampled on the selected receive clock
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rxd_q <= 1'b0;
      rxv_q <= 1'b0;
    end else if (clk_en) begin
      rxv_q <= ch_rise[1];
      if (ch_rise[1]) begin
        rxd_q <= ctrl_q.input_sel ? data_in2 : data_in1; // [R16]
      end
    end
  end

  assign rx_data = rxd_q;
  assign rx_data_valid = rxv_q;
  assign cdr_enable = !ctrl_q.input_sel; // [R16]
  assign resync_en = ctrl_q.auto_sync; // [R17]

  // alert request; off volume suppresses it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      alert_q <= 1'b0;
    end else if (clk_en) begin
      alert_q <= rx_err_p && ctrl_q.alert_vol != 2'h0; // [R8]
    end
  end

  assign alert_req = alert_q;
  assign alert_level = ctrl_q.alert_vol; // [R8]

  // sticky status, write one to clear; a new event beats the clear
  always_comb begin
    ev_now = '{tx_err: tx_err_p, rx_err: rx_err_p, interval: intv_q, done: done_q};
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d = stat_q & ~reg_wdata[IRQ_W-1:0];
    end
    stat_d = stat_d | ev_now;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stat_q <= '0;
      mask_q <= MASK_RST;
    end else if (clk_en) begin
      stat_q <= stat_d;
      if (wr_mask) begin
        mask_q <= reg_wdata[IRQ_W-1:0];
      end
    end
  end

  assign irq = |(stat_q & mask_q);

  // read data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h00000000;
    end else if (clk_en) begin
      rdata_q <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          OFS_CTRL: rdata_q <= {23'h000000, ctrl_q};
          OFS_DAY: rdata_q <= {28'h0000000, day_q};
          OFS_HMS: rdata_q <= {11'h000, hour_q, 2'h0, min_q, 2'h0, sec_q};
          OFS_STATUS: rdata_q <= {31'h00000000, measuring};
          OFS_ELAPSED: rdata_q <= {12'h000, elapsed_q};
          OFS_IRQ_STAT: rdata_q <= {28'h0000000, stat_q};
          OFS_IRQ_MASK: rdata_q <= {28'h0000000, mask_q};
          default: rdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_q;
endmodule : emc_measure_ctrl

// File: tb/emc_properties.sv
// assertions on the measurement-control ports
`timescale 1ns/1ps
module emc_properties
  import emc_pkg::*;
(
  // clock, reset
  input logic ref_clk,
  input logic rstn,
  // register port
  input logic clk_en,
  input logic [7:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  // observed
  input emc_ev_s ev,
  input logic trig_out,
  input logic cdr_enable,
  input logic alert_req,
  input logic [1:0] alert_level,
  input logic measuring,
  input logic meas_done,
  input logic interval_end
);
  logic [2:0] sel_q;
  logic inp_q;
  wire cmd_wr = clk_en && reg_wr && reg_addr == OFS_CMD;
  wire go_wr = cmd_wr && reg_wdata[CMD_START_BIT];
  wire halt_wr = cmd_wr && reg_wdata[CMD_STOP_BIT];
  // shadow of the selection fields, the ports alone cannot tell them
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sel_q <= 3'h0;
      inp_q <= 1'b0;
    end else if (clk_en && reg_wr && reg_addr == OFS_CTRL) begin
      sel_q <= reg_wdata[8:6];
      inp_q <= reg_wdata[2];
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  chk_start_cause: assert property ($rose(measuring) |-> $past(go_wr))
    else $error("run without start");
  chk_end_done: assert property ($fell(measuring) |-> ##[0:1] meas_done)
    else $error("end without done");
  chk_idle_stop: assert property (!measuring && halt_wr && !go_wr |=> !measuring && !meas_done)
    else $error("idle stop acted");
  chk_stop_ends: assert property (measuring && halt_wr |-> ##[1:2] !measuring)
    else $error("stop ignored");
  chk_alert_vol: assert property (alert_req |-> alert_level != 2'h0)
    else $error("alert while off");
  chk_err_trig: assert property (sel_q == 3'h7 && $rose(ev.rx_err_det) |-> ##[1:2] trig_out)
    else $error("no error trigger");
  chk_err_pulse: assert property (sel_q[1:0] == 2'h3 && $stable(sel_q) && trig_out |=> !trig_out)
    else $error("trigger pulse too wide");
  chk_input_path: assert property (cdr_enable == !inp_q)
    else $error("recovery enable wrong");
  cover property ($fell(measuring) && meas_done);
  cover property (interval_end);
  cover property (alert_req);
endmodule : emc_properties

// File: tb/emc_dut_model.sv
// device-under-test stand-in: link clocks and a prbs7 stream
`timescale 1ns/1ps
module emc_dut_model (
  // reference
  input logic ref_clk,
  // link clocks and data
  output logic tx_clk,
  output logic rec_clk,
  output logic ext_clk,
  output logic data_in1,
  output logic data_in2
);
  logic [6:0] lfsr_q = 7'h7f;
  initial begin
    tx_clk = 1'b0;
    rec_clk = 1'b0;
    ext_clk = 1'b0;
  end
  // fastest rate an edge detector still sees; data moves on the falling edge
  always @(posedge ref_clk) begin
    tx_clk <= ~tx_clk;
    rec_clk <= ~rec_clk;
    ext_clk <= ~ext_clk;
    if (rec_clk) lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
  end
  assign data_in1 = lfsr_q[0];
  assign data_in2 = lfsr_q[6];
endmodule : emc_dut_model

// File: tb/emc_measure_ctrl_tb.sv
// self-checking bench for the measurement-control block
`timescale 1ns/1ps
module emc_measure_ctrl_tb;
  import emc_pkg::*;
  localparam int SC = 4;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  emc_ev_s ev = '0;
  logic [31:0] reg_rdata;
  logic [1:0] alert_level;
  logic irq, trig_out, rx_data_valid, cdr_enable, resync_en, trig_p;
  logic alert_req, measuring, meas_done, interval_end;
  wire tx_clk, rec_clk, ext_clk, data_in1, data_in2;
  int bad_count = 0;
  int num_checks = 0;
  int cnt[6];
  always #25 ref_clk = ~ref_clk;
  emc_dut_model dut (.ref_clk, .tx_clk, .rec_clk, .ext_clk, .data_in1, .data_in2);
  emc_measure_ctrl #(.SEC_CYCLES(SC)) uut (.ref_clk, .rstn, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq, .tx_clk, .rec_clk, .ext_clk, .data_in1, .data_in2, .pat_is_prbs(1'b1), .ev,
    .trig_out, .rx_data(), .rx_data_valid, .cdr_enable, .resync_en, .alert_req, .alert_level, .measuring,
    .meas_done, .interval_end);
  // tallies see the cycle before each edge, so they never race the drivers
  always @(posedge ref_clk) begin
    cnt[0] += measuring;
    cnt[1] += meas_done;
    cnt[2] += interval_end;
    cnt[3] += trig_out & ~trig_p;
    cnt[4] += alert_req;
    cnt[5] += rx_data_valid;
    trig_p = trig_out;
  end
  task automatic ck(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (e !== g) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : ck
  task automatic wt(int n);
    repeat (n) @(posedge ref_clk);
  endtask : wt
  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    wt(1);
    reg_wr <= 1'b0;
    wt(1);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e, string n);
    reg_addr <= a;
    reg_rd <= 1'b1;
    wt(1);
    reg_rd <= 1'b0;
    #1 ck(n, e, reg_rdata);
    wt(1);
  endtask : rd
  task automatic clr();
    @(negedge ref_clk) cnt = '{default: 0};
    wt(1);
  endtask : clr
  task automatic ctl(logic [2:0] s, logic [1:0] v, logic a, logic i, logic [1:0] m);
    wr(OFS_CTRL, {23'h0, s, v, a, i, m});
  endtask : ctl
  task automatic t_single();
    ck("cdr rst", 1, cdr_enable);
    ck("sync rst", 1, resync_en);
    rd(8'h20, 0, "unmapped");
    wr(OFS_DAY, 32'hf);
    rd(OFS_DAY, 32'ha, "day");
    wr(OFS_HMS, 32'h3f3f3f);
    rd(OFS_HMS, 32'h173b3b, "hms");
    wr(OFS_DAY, 32'h0);
    wr(OFS_HMS, 32'h2);
    clr();
    wr(OFS_CMD, 32'h1);
    wt(3 * SC);
    ck("single len", 2 * SC, cnt[0]);
    ck("single done", 1, cnt[1]);
  endtask : t_single
  task automatic t_manual();
    ctl(3'h0, 2'h0, 1'b1, 1'b0, 2'h1);
    clr();
    wr(OFS_CMD, 32'h1);
    wt(4 * SC);
    #1 ck("manual run", 1, measuring);
    rd(OFS_STATUS, 32'h1, "status");
    wr(OFS_CMD, 32'h1);
    wr(OFS_CMD, 32'h2);
    wr(OFS_CMD, 32'h2);
    wt(2);
    ck("manual done", 1, cnt[1]);
  endtask : t_manual
  task automatic t_repeat();
    ctl(3'h0, 2'h0, 1'b1, 1'b0, 2'h2);
    wr(OFS_HMS, 32'h1);
    clr();
    wr(OFS_CMD, 32'h1);
    wt(3 * SC + 1);
    #1 ck("repeat run", 1, measuring);
    wr(OFS_CMD, 32'h2);
    wt(2);
    ck("intervals", 3, cnt[2]);
  endtask : t_repeat
  task automatic t_trig();
    logic [2:0] s[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
    int e[6] = '{20, 5, 3, 20, 5, 3};
    foreach (s[i]) begin
      ctl(s[i], 2'h0, 1'b1, 1'b0, 2'h0);
      clr();
      wt(640);
      ck("trig rate", 1, (cnt[3] - e[i]) inside {[-1:1]});
    end
  endtask : t_trig
  task automatic t_event();
    wr(OFS_IRQ_MASK, 32'h4);
    ctl(3'h3, 2'h0, 1'b1, 1'b0, 2'h0);
    clr();
    ev.tx_err_ins <= 1'b1;
    wt(4);
    ev.tx_err_ins <= 1'b0;
    wt(4);
    ck("tx err", 1, cnt[3]);
    for (int v = 0; v < 4; v++) begin
      ctl(3'h7, v[1:0], 1'b1, 1'b0, 2'h0);
      clr();
      ev.rx_err_det <= 1'b1;
      wt(4);
      #1 ck("irq", 1, irq);
      ev.rx_err_det <= 1'b0;
      wt(4);
      ck("rx err", 1, cnt[3]);
      ck("alert", v != 0, cnt[4]);
      ck("level", v, alert_level);
      wr(OFS_IRQ_STAT, 32'hf);
      #1 ck("irq clr", 0, irq);
    end
  endtask : t_event
  task automatic t_path();
    ctl(3'h0, 2'h0, 1'b0, 1'b1, 2'h0);
    clr();
    wt(20);
    ck("cdr off", 0, cdr_enable);
    ck("sync off", 0, resync_en);
    ck("ext data", 1, cnt[5] > 0);
    // a write with the enable low must leave the period untouched
    clk_en <= 1'b0;
    wr(OFS_DAY, 32'h3);
    clk_en <= 1'b1;
    rd(OFS_DAY, 32'h0, "frozen day");
  endtask : t_path
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    wt(4);
    rstn <= 1'b1;
    wt(1);
    t_single();
    t_manual();
    t_repeat();
    t_trig();
    t_event();
    t_path();
    end_of_test();
  end
  initial begin
    #500000;
    bad_count++;
    end_of_test();
  end
endmodule : emc_measure_ctrl_tb
bind emc_measure_ctrl emc_properties chk (.ref_clk, .rstn, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .ev,
  .trig_out, .cdr_enable, .alert_req, .alert_level, .measuring, .meas_done, .interval_end);
